/* core/vrx_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module vrx_axil_slave
   import vrx_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [AXI_ADDR_W-1:0]  awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [AXI_DATA_W-1:0]  wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [AXI_ADDR_W-1:0]  araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [AXI_DATA_W-1:0]       rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   output vrx_wr_s                     wr,
   input  wire logic                   wr_ok,
   output logic [AXI_ADDR_W-1:0]       rd_addr,
   input  wire logic [AXI_DATA_W-1:0]  rd_data,
   input  wire logic                   rd_ok
);

   logic                   aw_have_reg, aw_have_next;
   logic                   w_have_reg,  w_have_next;
   logic [AXI_ADDR_W-1:0]  awaddr_reg,  awaddr_next;
   logic [AXI_DATA_W-1:0]  wdata_reg,   wdata_next;
   logic [3:0]             wstrb_reg,   wstrb_next;
   logic                   bvalid_reg,  bvalid_next;
   logic [1:0]             bresp_reg,   bresp_next;
   logic                   rvalid_reg,  rvalid_next;
   logic [1:0]             rresp_reg,   rresp_next;
   logic [AXI_DATA_W-1:0]  rdata_reg,   rdata_next;
   logic                   do_wr;
   logic                   do_rd;

   // Address and data are latched separately, so either may come first
   assign awready = !aw_have_reg && !bvalid_reg;
   assign wready  = !w_have_reg && !bvalid_reg;
   assign arready = !rvalid_reg;
   assign do_wr   = aw_have_reg && w_have_reg && !bvalid_reg;
   assign do_rd   = arvalid && arready;
   assign rd_addr = araddr;

   always_comb begin
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      if (awvalid && awready) begin
         aw_have_next = 1'b1;
         awaddr_next  = awaddr;
      end
      if (wvalid && wready) begin
         w_have_next = 1'b1;
         wdata_next  = wdata;
         wstrb_next  = wstrb;
      end
      if (do_wr) begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_next = 1'b0;
      end
      if (do_rd) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_ok ? rd_data : '0;
         rresp_next  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= '0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         awaddr_reg  <= awaddr_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   // One driver for the whole carrier
   assign wr = '{en: do_wr, addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

endmodule

/* core/vrx_ctrl_top.sv */
// Mode, correction enable and reset control of the serial video receiver
// What this block does
// - Enable pin high enables correction features
// - Checksum-block CRC fix only for SD
// - Line CRC and line number fix HD-only
// - Disable register bit turns feature off
// - Enable pin low disables all features
// - Mode indicator direction follows detection mode
// - Auto: indicator high only when locked video
// - External indicator high, ASI low: video mode
// - External indicator low: no decode or align
// - External indicator low: no corrections at all
// - Host reset: defaults, all pins high-impedance
// - Scan reset: defaults, scan held in reset
// - Reset released: scan sequence runs again
// - Auto: rate pin low HD, high SD
// - Test select picks host or scan function
`timescale 1ns/1ps
module vrx_ctrl_top
   import vrx_pkg::*;
(
   input  wire logic                   CLK,
   input  wire logic                   SYS_RST,
   input  wire logic [AXI_ADDR_W-1:0]  S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [AXI_DATA_W-1:0]  S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [AXI_ADDR_W-1:0]  S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [AXI_DATA_W-1:0]       S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   input  wire logic                   CORRECTION_ENABLE_PIN,
   input  wire logic                   VIDEO_MODE_INDICATOR_I,
   output logic                        VIDEO_MODE_INDICATOR_O,
   output logic                        VIDEO_MODE_INDICATOR_OE,
   input  wire logic                   ASI_MODE_SELECT,
   input  wire logic                   RATE_SELECT_I,
   output logic                        RATE_SELECT_O,
   output logic                        RATE_SELECT_OE,
   input  wire logic                   AUTO_DETECT_SELECT,
   input  wire logic                   TEST_PORT_SELECT,
   input  wire logic                   COMBINED_RESET_N,
   input  wire logic                   STREAM_LOCKED,
   input  wire logic                   STREAM_IS_VIDEO,
   input  wire logic                   STREAM_IS_SD,
   output vrx_feat_s                   FEATURE_ENABLE,
   output logic                        SERIAL_DECODE_EN,
   output logic                        FUNC_DEFAULT_RST,
   output logic                        PIN_IO_ENABLE,
   output logic                        LOOP_THROUGH_SERIAL_OUT_OE,
   output logic                        SCAN_RESET,
   output logic                        SCAN_RUN,
   output logic                        HOST_IF_SELECT
);

   logic [PIN_SYNC_W-1:0]  pins_async;
   logic [PIN_SYNC_W-1:0]  pins_sync;
   logic                   en_s, ind_s, asi_s, rate_s, auto_s, tsel_s, rstn_s;
   vrx_wr_s                wr;
   logic                   wr_ok;
   logic [AXI_ADDR_W-1:0]  rd_addr;
   logic [AXI_DATA_W-1:0]  rd_data;
   logic                   rd_ok;

   vrx_mode_e              mode_reg, mode_next;
   vrx_feat_s              dis_reg, dis_next;
   vrx_feat_s              feat_reg, feat_next;
   logic                   decode_reg, decode_next;
   logic                   ind_o_reg, ind_o_next;
   logic                   ind_oe_reg, ind_oe_next;
   logic                   rate_o_reg, rate_o_next;
   logic                   rate_oe_reg, rate_oe_next;
   logic                   frst_reg, frst_next;
   logic                   pin_en_reg, pin_en_next;
   logic                   scan_rst_reg, scan_rst_next;
   logic                   scan_run_reg, scan_run_next;
   logic                   host_sel_reg, host_sel_next;
   logic                   video_ok;
   logic                   sd_rate;

   // Word address match on the register bus
   function automatic logic is_reg(input logic [AXI_ADDR_W-1:0] a,
                                   input logic [AXI_ADDR_W-1:0] ofs);
      return a[AXI_ADDR_W-1:2] == ofs[AXI_ADDR_W-1:2];
   endfunction

   // Rate qualification after the enable pin and disable bits
   function automatic vrx_feat_s feat_gate(input logic en, input vrx_feat_s dis,
                                           input logic video, input logic sd);
      vrx_feat_s f;
      f = (en && video) ? vrx_feat_s'(~dis) : vrx_feat_s'('0);
      f.edh_crc_fix  = f.edh_crc_fix & sd;
      f.line_crc_fix = f.line_crc_fix & ~sd;
      f.line_num_fix = f.line_num_fix & ~sd;
      return f;
   endfunction

   assign pins_async = {CORRECTION_ENABLE_PIN, VIDEO_MODE_INDICATOR_I, ASI_MODE_SELECT,
                        RATE_SELECT_I, AUTO_DETECT_SELECT, TEST_PORT_SELECT,
                        COMBINED_RESET_N};

   // Reset pin synchronises to low so the core starts held in defaults
   vrx_sync #(
      .W    (PIN_SYNC_W),
      .INIT ('0)
   ) u_pin_sync (
      .clk (CLK),
      .rst (SYS_RST),
      .d   (pins_async),
      .q   (pins_sync)
   );

   assign {en_s, ind_s, asi_s, rate_s, auto_s, tsel_s, rstn_s} = pins_sync;

   vrx_axil_slave u_bus (
      .clk     (CLK),
      .rst     (SYS_RST),
      .awaddr  (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .bresp   (S_AXI_BRESP),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .araddr  (S_AXI_ARADDR),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .wr      (wr),
      .wr_ok   (wr_ok),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   assign wr_ok = is_reg(wr.addr, OFS_CTRL) || is_reg(wr.addr, OFS_STATUS);
   assign rd_ok = is_reg(rd_addr, OFS_CTRL) || is_reg(rd_addr, OFS_STATUS);

   always_comb begin
      rd_data = '0;
      if (is_reg(rd_addr, OFS_CTRL)) begin
         rd_data[FEAT_W-1:0] = dis_reg;
      end else if (is_reg(rd_addr, OFS_STATUS)) begin
         rd_data[STAT_FEAT_LSB +: FEAT_W] = feat_reg;
         rd_data[STAT_VIDEO_BIT]          = video_ok;
         rd_data[STAT_SD_BIT]             = sd_rate;
         rd_data[STAT_AUTO_BIT]           = auto_s;
         rd_data[STAT_TSEL_BIT]           = tsel_s;
         rd_data[STAT_FRST_BIT]           = frst_reg;
         rd_data[STAT_EN_BIT]             = en_s;
      end
   end

   // Disable bits return to defaults while the functional reset is held
   always_comb begin
      dis_next = dis_reg;
      if (!rstn_s) begin
         dis_next = DIS_RESET;
      end else if (wr.en && is_reg(wr.addr, OFS_CTRL) && wr.strb[0]) begin
         dis_next = wr.data[FEAT_W-1:0];
      end
   end

   always_comb begin
      if (!rstn_s) begin
         mode_next = VRX_HELD;
      end else if (auto_s) begin
         mode_next = VRX_AUTO;
      end else begin
         mode_next = VRX_EXT;
      end
   end

   always_comb begin
      video_ok    = 1'b0;
      sd_rate     = rate_s;
      decode_next = 1'b0;
      case (mode_next)
         VRX_AUTO: begin
            video_ok    = 1'b1;
            sd_rate     = STREAM_IS_SD;
            decode_next = 1'b1;
         end
         VRX_EXT: begin
            video_ok    = ind_s && !asi_s;
            decode_next = ind_s;
         end
         VRX_HELD: begin
            video_ok    = 1'b0;
            decode_next = 1'b0;
         end
         default: begin
            video_ok    = 1'b0;
            decode_next = 1'b0;
         end
      endcase
      feat_next     = feat_gate(en_s, dis_reg, video_ok, sd_rate);
      pin_en_next   = rstn_s || tsel_s;
      ind_oe_next   = auto_s && pin_en_next;
      rate_oe_next  = auto_s && pin_en_next;
      ind_o_next    = rstn_s && STREAM_LOCKED && STREAM_IS_VIDEO;
      rate_o_next   = rstn_s && STREAM_IS_SD;
      frst_next     = !rstn_s;
      scan_rst_next = tsel_s && !rstn_s;
      scan_run_next = tsel_s && rstn_s;
      host_sel_next = !tsel_s;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode_reg     <= VRX_HELD;
         dis_reg      <= DIS_RESET;
         feat_reg     <= '0;
         decode_reg   <= 1'b0;
         ind_o_reg    <= 1'b0;
         ind_oe_reg   <= 1'b0;
         rate_o_reg   <= 1'b0;
         rate_oe_reg  <= 1'b0;
         frst_reg     <= 1'b1;
         pin_en_reg   <= 1'b0;
         scan_rst_reg <= 1'b0;
         scan_run_reg <= 1'b0;
         host_sel_reg <= 1'b1;
      end else begin
         mode_reg     <= mode_next;
         dis_reg      <= dis_next;
         feat_reg     <= feat_next;
         decode_reg   <= decode_next;
         ind_o_reg    <= ind_o_next;
         ind_oe_reg   <= ind_oe_next;
         rate_o_reg   <= rate_o_next;
         rate_oe_reg  <= rate_oe_next;
         frst_reg     <= frst_next;
         pin_en_reg   <= pin_en_next;
         scan_rst_reg <= scan_rst_next;
         scan_run_reg <= scan_run_next;
         host_sel_reg <= host_sel_next;
      end
   end

   assign FEATURE_ENABLE             = feat_reg;
   assign SERIAL_DECODE_EN           = decode_reg;
   assign VIDEO_MODE_INDICATOR_O     = ind_o_reg;
   assign VIDEO_MODE_INDICATOR_OE    = ind_oe_reg;
   assign RATE_SELECT_O              = rate_o_reg;
   assign RATE_SELECT_OE             = rate_oe_reg;
   assign FUNC_DEFAULT_RST           = frst_reg;
   assign PIN_IO_ENABLE              = pin_en_reg;
   assign LOOP_THROUGH_SERIAL_OUT_OE = pin_en_reg;
   assign SCAN_RESET                 = scan_rst_reg;
   assign SCAN_RUN                   = scan_run_reg;
   assign HOST_IF_SELECT             = host_sel_reg;

   sequence host_reset_s;
      !rstn_s && !tsel_s;
   endsequence

   sequence scan_reset_s;
      !rstn_s && tsel_s;
   endsequence

   sequence auto_run_s;
      rstn_s && auto_s;
   endsequence

   pin_on_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (auto_run_s and (en_s && dis_reg == DIS_RESET))
      |=> FEATURE_ENABLE.anc_cksum_fix && FEATURE_ENABLE.trs_fix
          && FEATURE_ENABLE.illegal_remap) else $error("features not enabled");
   edh_sd_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (auto_run_s and !STREAM_IS_SD) |=> !FEATURE_ENABLE.edh_crc_fix)
      else $error("edh fix active on HD");
   line_hd_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (auto_run_s and (STREAM_IS_SD && en_s && dis_reg == DIS_RESET))
      |=> !FEATURE_ENABLE.line_crc_fix && !FEATURE_ENABLE.line_num_fix
          && FEATURE_ENABLE.edh_crc_fix) else $error("line fixes wrong on SD");
   dis_bit_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (rstn_s && dis_reg.trs_fix) |=> !FEATURE_ENABLE.trs_fix)
      else $error("disabled feature active");
   pin_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !en_s |=> FEATURE_ENABLE == '0) else $error("features on with pin low");
   ind_auto_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      auto_run_s |=> VIDEO_MODE_INDICATOR_OE
                     && VIDEO_MODE_INDICATOR_O == $past(STREAM_LOCKED && STREAM_IS_VIDEO))
      else $error("indicator wrong in auto mode");
   ext_dir_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !auto_s |=> !VIDEO_MODE_INDICATOR_OE && !RATE_SELECT_OE)
      else $error("pin driven in external mode");
   ext_low_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (rstn_s && !auto_s && !ind_s) |=> !SERIAL_DECODE_EN && FEATURE_ENABLE == '0)
      else $error("decode or fix with indicator low");
   ext_video_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (rstn_s && !auto_s && ind_s && !asi_s) |=> SERIAL_DECODE_EN)
      else $error("video mode not decoding");
   host_rst_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      host_reset_s |=> FUNC_DEFAULT_RST && !PIN_IO_ENABLE && !LOOP_THROUGH_SERIAL_OUT_OE
                       && !VIDEO_MODE_INDICATOR_OE && !RATE_SELECT_OE)
      else $error("pins not released in host reset");
   mode_held_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !rstn_s |=> mode_reg == VRX_HELD) else $error("mode not held in reset");
   scan_rst_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      scan_reset_s |=> FUNC_DEFAULT_RST && SCAN_RESET && !SCAN_RUN && dis_reg == DIS_RESET)
      else $error("scan reset not held");
   scan_run_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      scan_reset_s ##1 (rstn_s && tsel_s) |=> SCAN_RUN && !SCAN_RESET && !FUNC_DEFAULT_RST)
      else $error("scan not resumed");
   rate_auto_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      auto_run_s |=> RATE_SELECT_OE && RATE_SELECT_O == $past(STREAM_IS_SD))
      else $error("rate pin wrong in auto mode");
   port_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ##1 HOST_IF_SELECT == !$past(tsel_s)) else $error("shared pin function wrong");
   pin_sync_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ##2 en_s == $past(CORRECTION_ENABLE_PIN, 2)) else $error("enable pin not synced");

endmodule

/* core/vrx_pkg.sv */
// Shared constants and carrier types for the receiver mode and correction control block
package vrx_pkg;

   localparam int          AXI_ADDR_W     = 4;
   localparam int          AXI_DATA_W     = 32;
   localparam int          FEAT_W         = 6;

   // Register byte offsets
   localparam logic [3:0]  OFS_CTRL       = 4'h0;
   localparam logic [3:0]  OFS_STATUS     = 4'h4;

   // Reset value of the per-feature disable bits
   localparam logic [5:0]  DIS_RESET      = 6'h00;

   // Status word field positions
   localparam int          STAT_FEAT_LSB  = 0;
   localparam int          STAT_VIDEO_BIT = 8;
   localparam int          STAT_SD_BIT    = 9;
   localparam int          STAT_AUTO_BIT  = 10;
   localparam int          STAT_TSEL_BIT  = 11;
   localparam int          STAT_FRST_BIT  = 12;
   localparam int          STAT_EN_BIT    = 13;

   // AXI response codes
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Synchroniser width for the asynchronous control pins
   localparam int          PIN_SYNC_W     = 7;

   typedef enum logic [2:0] {
      VRX_HELD,
      VRX_AUTO,
      VRX_EXT
   } vrx_mode_e;

   // One bit per correction feature, same layout as the disable register
   typedef struct packed {
      logic illegal_remap;
      logic trs_fix;
      logic line_num_fix;
      logic line_crc_fix;
      logic anc_cksum_fix;
      logic edh_crc_fix;
   } vrx_feat_s;

   typedef struct packed {
      logic                    en;
      logic [AXI_ADDR_W-1:0]   addr;
      logic [AXI_DATA_W-1:0]   data;
      logic [3:0]              strb;
   } vrx_wr_s;

endpackage

/* core/vrx_sync.sv */
// Two-flop synchroniser for asynchronous control pins
`timescale 1ns/1ps
module vrx_sync
   import vrx_pkg::*;
#(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [W-1:0]  d,
   output logic [W-1:0]       q
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s1_next;
   logic [W-1:0] s2_next;

   // First stage is read only by the second
   always_comb begin
      s1_next = d;
      s2_next = s1_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   assign q = s2_reg;

endmodule

/* test/tb.sv */
// Self-checking bench for the mode and correction control block
`timescale 1ns/1ps
module tb import vrx_pkg::*; ;
   logic        CLK = 0, SYS_RST = 1, ind = 0, rt = 1, rq = 1;
   logic [3:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, S_AXI_WSTRB = 4'hF;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, d;
   logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
   logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
   logic        VIDEO_MODE_INDICATOR_I, VIDEO_MODE_INDICATOR_O, VIDEO_MODE_INDICATOR_OE;
   logic        RATE_SELECT_I, RATE_SELECT_O, RATE_SELECT_OE, COMBINED_RESET_N;
   logic        CORRECTION_ENABLE_PIN = 0, ASI_MODE_SELECT = 0, AUTO_DETECT_SELECT = 1;
   logic        TEST_PORT_SELECT = 0, STREAM_LOCKED = 0, STREAM_IS_VIDEO = 0, STREAM_IS_SD = 0;
   logic        SERIAL_DECODE_EN, FUNC_DEFAULT_RST, PIN_IO_ENABLE, LOOP_THROUGH_SERIAL_OUT_OE;
   logic        SCAN_RESET, SCAN_RUN, HOST_IF_SELECT;
   vrx_feat_s   FEATURE_ENABLE;
   logic [5:0]  dis = 0;
   int          bad_count = 0, cmp_count = 0;
   vrx_ctrl_top u_vrx_ctrl_top (.*);
   vrx_pin_model u_vrx_pin_model (.clk(CLK), .auto_sel(AUTO_DETECT_SELECT), .ext_ind(ind),
      .ext_rate(rt), .rst_req_n(rq), .ind_o(VIDEO_MODE_INDICATOR_O),
      .ind_oe(VIDEO_MODE_INDICATOR_OE), .rate_o(RATE_SELECT_O), .rate_oe(RATE_SELECT_OE),
      .ind_pin(VIDEO_MODE_INDICATOR_I), .rate_pin(RATE_SELECT_I), .rst_n(COMBINED_RESET_N));
   initial forever #2 CLK = ~CLK;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge CLK);
   endtask
   // Bench expectation; auto mode takes the rate from the datapath, external from the pin
   function automatic logic [5:0] fexp();
      logic sd;
      sd = AUTO_DETECT_SELECT ? STREAM_IS_SD : rt;
      fexp = (CORRECTION_ENABLE_PIN && (AUTO_DETECT_SELECT || (ind && !ASI_MODE_SELECT)))
             ? ~dis : 6'h00;
      fexp = fexp & {2'h3, !sd, !sd, 1'h1, sd};
   endfunction
   task automatic wr(logic [3:0] a, logic [31:0] v, output logic [1:0] rs);
      int n = 0;
      // Let an edge pass so back-to-back calls never drive a strobe twice at once
      @(posedge CLK);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= v;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      S_AXI_BREADY  <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         n++;
      end while (S_AXI_BVALID !== 1'b1 && n < 50);
      S_AXI_BREADY <= 1'b0;
      rs = S_AXI_BRESP;
      if (S_AXI_BVALID !== 1'b1) begin
         bad_count++;
         end_sim();
      end
   endtask
   task automatic rd(logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n = 0;
      @(posedge CLK);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY  <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         n++;
      end while (S_AXI_RVALID !== 1'b1 && n < 50);
      S_AXI_RREADY <= 1'b0;
      v  = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      if (S_AXI_RVALID !== 1'b1) begin
         bad_count++;
         end_sim();
      end
   endtask
   initial begin
      void'($urandom(11));
      wt(5);
      SYS_RST <= 1'b0;
      wt(8);
      chk("func_rst", 0, FUNC_DEFAULT_RST);
      rd(OFS_CTRL, d, r);
      chk("ctrl_reset", DIS_RESET, d);
      rd(4'h8, d, r);
      chk("unmapped_rd", RESP_SLVERR, r);
      chk("unmapped_data", 0, d);
      wr(4'hC, 32'h0000_003F, r);
      chk("unmapped_wr", RESP_SLVERR, r);
      // Byte lane 0 off: the write is answered but must not land
      S_AXI_WSTRB <= 4'h0;
      wr(OFS_CTRL, 32'h0000_003F, r);
      chk("strb_resp", RESP_OKAY, r);
      S_AXI_WSTRB <= 4'hF;
      wr(OFS_STATUS, 32'h0000_003F, r);
      chk("status_wr", RESP_OKAY, r);
      rd(OFS_CTRL, d, r);
      chk("strb_off", DIS_RESET, d);
      for (int i = 0; i < 24; i++) begin
         // First two passes pin the corners: auto SD video, enable low then high, none disabled
         CORRECTION_ENABLE_PIN <= (i < 2) ? i[0] : 1'($urandom);
         {AUTO_DETECT_SELECT, ind, ASI_MODE_SELECT, rt} <= (i < 2) ? 4'hC : 4'($urandom);
         {STREAM_LOCKED, STREAM_IS_VIDEO, STREAM_IS_SD} <= (i < 2) ? 3'h7 : 3'($urandom);
         dis = (i < 2) ? 6'h00 : 6'($urandom);
         wt(14);
         wr(OFS_CTRL, {26'h0, dis}, r);
         chk("wr_resp", RESP_OKAY, r);
         wt(6);
         chk("feat", fexp(), FEATURE_ENABLE);
         chk("decode", AUTO_DETECT_SELECT || ind, SERIAL_DECODE_EN);
         chk("ind_oe", AUTO_DETECT_SELECT, VIDEO_MODE_INDICATOR_OE);
         chk("rate_oe", AUTO_DETECT_SELECT, RATE_SELECT_OE);
         if (AUTO_DETECT_SELECT) begin
            chk("ind_o", STREAM_LOCKED && STREAM_IS_VIDEO, VIDEO_MODE_INDICATOR_O);
            chk("rate_o", STREAM_IS_SD, RATE_SELECT_O);
         end
         rd(OFS_STATUS, d, r);
         chk("status", fexp(), d[5:0]);
         chk("status_en", CORRECTION_ENABLE_PIN, d[STAT_EN_BIT]);
         chk("status_frst", 0, d[STAT_FRST_BIT]);
      end
      for (int t = 0; t < 2; t++) begin
         TEST_PORT_SELECT <= t[0];
         AUTO_DETECT_SELECT <= 1'b1;
         rq <= 1'b0;
         wt(6);
         chk("func_rst", 1, FUNC_DEFAULT_RST);
         chk("feat_rst", 0, FEATURE_ENABLE);
         chk("host_sel", !t[0], HOST_IF_SELECT);
         if (t == 0) begin
            chk("pin_io", 0, PIN_IO_ENABLE);
            chk("loop_oe", 0, LOOP_THROUGH_SERIAL_OUT_OE);
            chk("ind_oe", 0, VIDEO_MODE_INDICATOR_OE);
         end else
            chk("scan_rst", 1, SCAN_RESET);
         rq <= 1'b1;
         wt(6);
         chk("func_rst", 0, FUNC_DEFAULT_RST);
         if (t == 1) chk("scan_run", 1, SCAN_RUN);
      end
      end_sim();
   end
endmodule

/* test/vrx_pin_model.sv */
// Application-side model of the static control pins and the two-way pins
`timescale 1ns/1ps
module vrx_pin_model (
   input  wire logic clk,
   input  wire logic auto_sel,
   input  wire logic ext_ind,
   input  wire logic ext_rate,
   input  wire logic rst_req_n,
   input  wire logic ind_o,
   input  wire logic ind_oe,
   input  wire logic rate_o,
   input  wire logic rate_oe,
   output logic      ind_pin,
   output logic      rate_pin,
   output logic      rst_n
);
   logic       tog  = 1'b0;
   logic       last = 1'b1;
   logic [2:0] hold = 3'h0;
   // Rate pin has a pull-up; an undriven indicator toggles so it never looks driven
   assign rate_pin = rate_oe ? rate_o : (auto_sel ? 1'b1 : ext_rate);
   assign ind_pin  = ind_oe ? ind_o : (auto_sel ? tog : ext_ind);
   assign rst_n    = rst_req_n && (hold == 3'h0);
   always_ff @(posedge clk) begin
      tog  <= ~tog;
      last <= ext_rate;
      if (!auto_sel && ext_rate != last)
         hold <= 3'h4;
      else if (hold != 3'h0)
         hold <= hold - 3'h1;
   end
endmodule
